// ===== logic/ebc_map.vh
// Register map, field layout and timing constants of the external bus block
// Operation
// [RULE1] Wait states equal fifteen minus the cycle wait field.
// [RULE2] Command delay bit 0: command starts one half clock after latch falls; here S_DLY holds it back one full clock.
// [RULE3] Command delay bit 1: command starts with latch strobe falling edge.
// [RULE4] Tristate wait bit 0 adds one idle state; 1 adds none.
// [RULE5] Bus type field selects 8/16-bit, multiplexed or demultiplexed bus.
// [RULE6] Region 0 bus type loads from the data port during reset.
// [RULE7] Latch stretch bit 1 gives a lengthened address latch strobe.
// [RULE8] Cycles run only for active regions hitting their address window.
// [RULE9] Ready enable 1 ends cycles on ready; 0 uses wait field alone.
// [RULE10] Ready polarity 0 means active low, 1 means active high.
// [RULE11] Read select gate 1 asserts chip select only during read command.
// [RULE12] Write select gate 1 asserts chip select only during write command.
// [RULE13] Write config 0 makes write pins low and high byte write strobes.
// [RULE14] Select line count picks three, two, none or five chip selects.
// [RULE15] Segment line count picks four, none, eight or two segment bits.
// [RULE16] Clock ratio select sets CPU clock multiple of the oscillator.
// [RULE17] Clock ratio bits latch only on a long hardware reset.
// [RULE18] Config bits latch from upper data port on every reset.
// [RULE19] Without pull-downs the latch captures all ones.
// [RULE20] Reset configuration latch is read only.
// [RULE21] Region 0 resets to zero if external access high, else enabled.
// [RULE22] Upper eight bits of reset configuration latch read as zero.
`ifndef EBC_MAP_VH
`define EBC_MAP_VH
`define EBC_OFS_RCFG    16'hF108
`define EBC_OFS_CTL0    16'hFF0C
`define EBC_OFS_CTL1    16'hFF14
`define EBC_OFS_CTL2    16'hFF16
`define EBC_OFS_CTL3    16'hFF18
`define EBC_OFS_CTL4    16'hFF1A
`define EBC_F_WAIT_HI   3
`define EBC_F_WAIT_LO   0
`define EBC_B_CMDDLY    4
`define EBC_B_TRIST     5
`define EBC_F_TYPE_HI   7
`define EBC_F_TYPE_LO   6
`define EBC_B_STRETCH   9
`define EBC_B_ACTIVE    10
`define EBC_B_RDYEN     12
`define EBC_B_RDYPOL    13
`define EBC_B_RDGATE    14
`define EBC_B_WRGATE    15
`define EBC_CTL_MASK    16'hF6FF
`define EBC_CTL_RESET   16'h0000
`define EBC_WAIT_MAX    4'hF
`define EBC_B_WRC       0
`define EBC_F_CSS_HI    2
`define EBC_F_CSS_LO    1
`define EBC_F_SAL_HI    4
`define EBC_F_SAL_LO    3
`define EBC_F_CLK_HI    7
`define EBC_F_CLK_LO    5
`define EBC_RCFG_RESET  8'hFF
`define EBC_RCFG_PORT_LSB 8
`endif

// ===== logic/ebc_top.v
// External bus region control, reset configuration latch and cycle sequencer
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "ebc_map.vh"
module ebc_top #(
  parameter NREG = 5
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        long_reset,
  input  wire        ext_access_n,
  input  wire [15:0] data_port_in,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        acc_req,
  input  wire        acc_write,
  input  wire [4:0]  acc_hit,
  output wire        acc_ready,
  input  wire        ready_pin,
  output reg         latch_strobe,
  output reg         rd_n,
  output reg         wr_n,
  output reg         bhe_n,
  output reg  [4:0]  cs_n,
  output wire        wr_low_n,
  output wire        wr_high_n,
  output wire [4:0]  cs_enable,
  output wire [7:0]  seg_enable,
  output wire [2:0]  clock_ratio,
  output wire [1:0]  bus_type,
  output wire        bus_wide,
  output wire        bus_muxed
);
  localparam S_IDLE = 6'h01;
  localparam S_ALE  = 6'h02;
  localparam S_DLY  = 6'h04;
  localparam S_CMD  = 6'h08;
  localparam S_TRI  = 6'h10;
  localparam S_STR  = 6'h20;
  localparam RCFG_LSB = `EBC_RCFG_PORT_LSB;

  reg  [15:0]      ctl_q [0:NREG-1];
  reg  [7:0]       rcfg_q;
  reg              boot_q;
  reg  [15:0]      port_s1_q;
  reg  [15:0]      port_s2_q;
  reg              ea_s1_q;
  reg              ea_s2_q;
  reg              lr_s1_q;
  reg              lr_s2_q;
  reg              rdy_s1_q;
  reg              rdy_s2_q;
  reg  [5:0]       state_q;
  reg  [5:0]       state_d;
  reg  [3:0]       cnt_q;
  reg  [3:0]       cnt_d;
  reg  [2:0]       sel_q;
  reg              wr_q;
  reg  [15:0]      cur;
  reg  [2:0]       hit_idx;
  reg              hit_any;
  reg  [2:0]       sel_d;
  reg              wr_d;
  reg  [15:0]      nxt;
  reg  [4:0]       cs_d;
  reg  [4:0]       cs_en_d;
  reg  [7:0]       seg_en_d;
  integer          i;
  integer          k;
  wire             rdy_active;
  wire             cmd_on;
  wire             gate_on;

  // Strap synchronisers run through reset; clearing them would make the
  // boot capture see zeros instead of the settled pins
  always @(posedge clk) begin
    port_s1_q <= data_port_in;
    port_s2_q <= port_s1_q;
    ea_s1_q   <= ext_access_n;
    ea_s2_q   <= ea_s1_q;
    lr_s1_q   <= long_reset;
    lr_s2_q   <= lr_s1_q;
  end

  // Ready synchroniser; costs two cycles before a cycle can end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= ready_pin;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // Straps are caught on the first clocked cycle after release
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // Latch lives across short resets, so its clock field keeps its value
  always @(posedge clk) begin
    if (boot_q) begin
      rcfg_q[`EBC_F_SAL_HI:`EBC_B_WRC] <= // [RULE19]
        port_s2_q[`EBC_F_SAL_HI+RCFG_LSB:`EBC_B_WRC+RCFG_LSB]; // [RULE18]
      if (lr_s2_q) begin // [RULE17]
        rcfg_q[`EBC_F_CLK_HI:`EBC_F_CLK_LO] <=
          port_s2_q[`EBC_F_CLK_HI+RCFG_LSB:`EBC_F_CLK_LO+RCFG_LSB];
      end
    end
  end

  // Control registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < NREG; i = i + 1) begin
        ctl_q[i] <= `EBC_CTL_RESET;
      end
    end else if (boot_q) begin
      ctl_q[0] <= `EBC_CTL_RESET; // [RULE21]
      if (!ea_s2_q) begin
        ctl_q[0][`EBC_B_ACTIVE]  <= 1'b1; // [RULE21]
        ctl_q[0][`EBC_B_STRETCH] <= 1'b1;
        ctl_q[0][`EBC_F_TYPE_HI:`EBC_F_TYPE_LO] <=
          port_s2_q[`EBC_F_TYPE_HI:`EBC_F_TYPE_LO]; // [RULE6]
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `EBC_OFS_CTL0: ctl_q[0] <= reg_wdata & `EBC_CTL_MASK;
        `EBC_OFS_CTL1: ctl_q[1] <= reg_wdata & `EBC_CTL_MASK;
        `EBC_OFS_CTL2: ctl_q[2] <= reg_wdata & `EBC_CTL_MASK;
        `EBC_OFS_CTL3: ctl_q[3] <= reg_wdata & `EBC_CTL_MASK;
        `EBC_OFS_CTL4: ctl_q[4] <= reg_wdata & `EBC_CTL_MASK;
        default: ;
      endcase
    end
  end

  // Read port; the reset latch ignores writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `EBC_OFS_RCFG: reg_rdata <= {8'h00, rcfg_q}; // [RULE20] [RULE22]
        `EBC_OFS_CTL0: reg_rdata <= ctl_q[0];
        `EBC_OFS_CTL1: reg_rdata <= ctl_q[1];
        `EBC_OFS_CTL2: reg_rdata <= ctl_q[2];
        `EBC_OFS_CTL3: reg_rdata <= ctl_q[3];
        `EBC_OFS_CTL4: reg_rdata <= ctl_q[4];
        default:       reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Decoded reset configuration
  assign wr_low_n  = rcfg_q[`EBC_B_WRC] ? 1'b1 : wr_n; // [RULE13]
  assign wr_high_n = rcfg_q[`EBC_B_WRC] ? 1'b1 : (wr_n | bhe_n); // [RULE13]
  // Unknown latch contents before the first boot fall to the widest case
  always @* begin
    case (rcfg_q[`EBC_F_CSS_HI:`EBC_F_CSS_LO])
      2'b00:   cs_en_d = 5'h07; // [RULE14]
      2'b01:   cs_en_d = 5'h03;
      2'b10:   cs_en_d = 5'h00;
      default: cs_en_d = 5'h1F;
    endcase
  end
  assign cs_enable = cs_en_d;

  always @* begin
    case (rcfg_q[`EBC_F_SAL_HI:`EBC_F_SAL_LO])
      2'b00:   seg_en_d = 8'h0F; // [RULE15]
      2'b01:   seg_en_d = 8'h00;
      2'b10:   seg_en_d = 8'hFF;
      default: seg_en_d = 8'h03;
    endcase
  end
  assign seg_enable = seg_en_d;

  // PLL lives outside; it decodes this code as the oscillator multiple
  assign clock_ratio = rcfg_q[`EBC_F_CLK_HI:`EBC_F_CLK_LO]; // [RULE16]

  // Region select: lowest active hit wins
  always @* begin
    hit_idx = 3'h0;
    hit_any = 1'b0;
    for (k = NREG - 1; k >= 0; k = k - 1) begin
      if (acc_hit[k] && ctl_q[k][`EBC_B_ACTIVE]) begin // [RULE8]
        hit_idx = k[2:0];
        hit_any = 1'b1;
      end
    end
  end

  always @* begin
    cur = ctl_q[sel_q];
  end

  // Region and direction of the cycle being launched; the registered
  // copies follow one edge later, too late for the first strobe
  always @* begin
    sel_d = sel_q;
    wr_d  = wr_q;
    if (state_q == S_IDLE && state_d == S_ALE) begin
      sel_d = hit_idx;
      wr_d  = acc_write;
    end
    nxt = ctl_q[sel_d];
  end

  assign bus_type  = cur[`EBC_F_TYPE_HI:`EBC_F_TYPE_LO]; // [RULE5]
  assign bus_wide  = bus_type[1];
  assign bus_muxed = bus_type[0];
  assign rdy_active = rdy_s2_q == cur[`EBC_B_RDYPOL]; // [RULE10]
  assign acc_ready = (state_q == S_IDLE) & ~boot_q;
  assign cmd_on = (state_d == S_CMD);
  assign gate_on = wr_d ? nxt[`EBC_B_WRGATE] : nxt[`EBC_B_RDGATE];

  // Cycle sequencer; one state is one clock period
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_IDLE: begin
        if (acc_req && hit_any && !boot_q) begin
          state_d = S_ALE;
        end
      end
      S_ALE: begin
        if (cur[`EBC_B_STRETCH]) begin
          state_d = S_STR; // [RULE7]
        end else if (cur[`EBC_B_CMDDLY]) begin
          state_d = S_CMD; // [RULE3]
        end else begin
          state_d = S_DLY; // [RULE2]
        end
        cnt_d = `EBC_WAIT_MAX - cur[`EBC_F_WAIT_HI:`EBC_F_WAIT_LO]; // [RULE1]
      end
      S_STR: begin
        state_d = cur[`EBC_B_CMDDLY] ? S_CMD : S_DLY;
      end
      S_DLY: begin
        state_d = S_CMD;
      end
      S_CMD: begin
        if (cur[`EBC_B_RDYEN]) begin
          if (rdy_active) begin // [RULE9]
            state_d = cur[`EBC_B_TRIST] ? S_IDLE : S_TRI; // [RULE4]
          end
        end else if (cnt_q == 4'h0) begin
          state_d = cur[`EBC_B_TRIST] ? S_IDLE : S_TRI; // [RULE4]
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      S_TRI: begin
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q      <= S_IDLE;
      cnt_q        <= 4'h0;
      sel_q        <= 3'h0;
      wr_q         <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sel_q   <= sel_d;
      wr_q    <= wr_d;
    end
  end

  // Chip selects; lines the straps leave unused never go low
  always @* begin
    cs_d = 5'h1F;
    if (state_d != S_IDLE && state_d != S_TRI) begin
      if (gate_on) begin
        cs_d[sel_d] = ~cmd_on; // [RULE11] [RULE12]
      end else begin
        cs_d[sel_d] = 1'b0;
      end
    end
    cs_d = cs_d | ~cs_en_d; // [RULE14]
  end

  // Bus pins are registered so they leave free of decode glitches
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_strobe <= 1'b0;
      rd_n         <= 1'b1;
      wr_n         <= 1'b1;
      bhe_n        <= 1'b1;
      cs_n         <= 5'h1F;
    end else begin
      latch_strobe <= (state_d == S_ALE) | (state_d == S_STR); // [RULE7]
      rd_n         <= ~(cmd_on & ~wr_d); // [RULE2] [RULE3]
      wr_n         <= ~(cmd_on & wr_d);
      bhe_n        <= ~((state_d != S_IDLE) & nxt[`EBC_F_TYPE_HI]);
      cs_n         <= cs_d;
    end
  end
endmodule // ebc_top

// ===== tb/ebc_mem_model.sv
// Slow external device answering on the ready line
`timescale 1ns/1ps
module ebc_mem_model (
  input  logic clk,
  input  logic rd_n,
  input  logic wr_n,
  input  logic pol,
  input  int   lag,
  output logic ready_pin
);
  int cnt = 0;
  initial ready_pin = 1'h1;
  // Ready answers only after lag command cycles, never at once
  always @(posedge clk) begin
    cnt = (rd_n && wr_n) ? 0 : cnt + 1;
    ready_pin <= (cnt > lag) ? pol : !pol;
  end
endmodule // ebc_mem_model

// ===== tb/ebc_monitor.sv
// Port checker for the external bus block
`timescale 1ns/1ps
module ebc_monitor (
  input logic        clk,
  input logic        nrst,
  input logic        reg_rd,
  input logic [15:0] reg_addr,
  input logic [15:0] reg_rdata,
  input logic        acc_req,
  input logic        acc_ready,
  input logic [4:0]  acc_hit,
  input logic        latch_strobe,
  input logic        rd_n,
  input logic        wr_n,
  input logic        wr_low_n,
  input logic [4:0]  cs_enable,
  input logic [7:0]  seg_enable,
  input logic [1:0]  bus_type,
  input logic        bus_wide,
  input logic        bus_muxed
);
  // Strap latch has no reset, so decoded outputs wait for the boot cycle
  logic [1:0] up_q;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_start; $rose(latch_strobe); endsequence
  sequence s_cmd_on; !rd_n || !wr_n; endsequence
  chk_rcfg_upper: assert property (reg_rd && reg_addr == 16'hF108
    |=> reg_rdata[15:8] == 8'h00) else $error("config upper byte set");
  chk_strobe_split: assert property (!wr_low_n |-> !wr_n)
    else $error("low byte strobe without write");
  chk_cs_count: assert property (up_q == 2'h3 |->
    cs_enable inside {5'h07, 5'h03, 5'h00, 5'h1F}) else $error("cs set");
  chk_seg_count: assert property (up_q == 2'h3 |->
    seg_enable inside {8'h0F, 8'h00, 8'hFF, 8'h03}) else $error("seg set");
  chk_type_decode: assert property (up_q == 2'h3 |->
    bus_wide == bus_type[1] && bus_muxed == bus_type[0])
    else $error("bus type decode");
  chk_busy_ready: assert property (latch_strobe |-> !acc_ready)
    else $error("ready during cycle");
  chk_cycle_cause: assert property (s_start |->
    $past(acc_req) && $past(acc_hit) != 5'h00) else $error("stray cycle");
  chk_cmd_hold: assert property (latch_strobe |-> rd_n && wr_n)
    else $error("command during latch");
  chk_cmd_soon: assert property (s_start |-> ##[1:3] s_cmd_on)
    else $error("command late");
endmodule // ebc_monitor

// ===== tb/ebc_top_tb.sv
// Self-checking bench for the external bus block
`timescale 1ns/1ps
module ebc_top_tb;
  logic        clk, nrst, long_reset, ext_access_n, reg_wr, reg_rd, acc_req;
  logic        acc_write, ready_pin, pol, latch_strobe, rd_n, wr_n, bhe_n;
  logic        wr_low_n, wr_high_n, bus_wide, bus_muxed, acc_ready;
  logic [15:0] data_port_in, reg_addr, reg_wdata, reg_rdata;
  logic [4:0]  acc_hit, cs_n, cs_enable;
  logic [7:0]  seg_enable;
  logic [2:0]  clock_ratio;
  logic [1:0]  bus_type;
  int          n_fail, tests_run, lag;
  ebc_top i_dut (.clk(clk), .nrst(nrst), .long_reset(long_reset),
    .ext_access_n(ext_access_n), .data_port_in(data_port_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_write(acc_write), .acc_hit(acc_hit), .acc_ready(acc_ready),
    .ready_pin(ready_pin), .latch_strobe(latch_strobe), .rd_n(rd_n),
    .wr_n(wr_n), .bhe_n(bhe_n), .cs_n(cs_n), .wr_low_n(wr_low_n),
    .wr_high_n(wr_high_n), .cs_enable(cs_enable), .seg_enable(seg_enable),
    .clock_ratio(clock_ratio), .bus_type(bus_type), .bus_wide(bus_wide),
    .bus_muxed(bus_muxed));
  ebc_mem_model i_mem (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .pol(pol),
    .lag(lag), .ready_pin(ready_pin));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  // Straps are held for the whole reset so the boot capture sees them
  task automatic do_reset(input logic [15:0] port, input logic lng);
    data_port_in <= port;
    long_reset   <= lng;
    nrst         <= 1'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    long_reset <= 1'h0;
  endtask
  task automatic t_straps;
    logic [4:0] cs_t [4] = '{5'h07, 5'h03, 5'h00, 5'h1F};
    logic [7:0] seg_t [4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};
    do_reset(16'hFF80, 1'h1);
    rd(16'hF108, 16'h00FF);
    rd(16'hFF0C, 16'h0000);
    for (int j = 0; j < 8; j++) begin
      do_reset({j[2:0], j[1:0], j[1:0], 1'h0, 8'h40}, 1'h1);
      check(clock_ratio, j[2:0]);
      check(cs_enable, cs_t[j % 4]);
      check(seg_enable, seg_t[j % 4]);
      rd(16'hF108, {8'h00, j[2:0], j[1:0], j[1:0], 1'h0});
    end
    do_reset(16'h0040, 1'h0);
    rd(16'hF108, 16'h00E0);
  endtask
  task automatic t_regs;
    ext_access_n <= 1'h0;
    do_reset(16'hFE80, 1'h1);
    rd(16'hFF0C, 16'h0680);
    check(bus_type, 2'h2);
    wr(16'hF108, 16'h0000);
    rd(16'hF108, 16'h00FE);
    rd(16'hFF00, 16'h0000);
  endtask
  task automatic bus(input logic [15:0] ctl, input logic w, input int e_ls,
                     input int e_cmd, input int e_busy);
    int n_ls, n_cmd, n_busy, n_cs, n_wl, n_wh;
    {n_ls, n_cmd, n_busy, n_cs, n_wl, n_wh} = '0;
    wr(16'hFF14, ctl);
    pol = ctl[13];
    @(posedge clk);
    acc_req   <= 1'h1;
    acc_write <= w;
    acc_hit   <= 5'h02;
    @(posedge clk);
    acc_req <= 1'h0;
    repeat (40) begin
      #1;
      n_ls += latch_strobe;
      n_cmd += !(rd_n && wr_n);
      n_busy += !acc_ready;
      n_cs += !cs_n[1];
      n_wl += !wr_low_n;
      n_wh += !wr_high_n;
      @(posedge clk);
    end
    check(n_ls, e_ls);
    if (e_cmd < 0)
      check(n_cmd > lag, 1'h1);
    else begin
      check(n_cmd, e_cmd);
      check(n_busy, e_busy);
      check(n_wl, w ? e_cmd : 0);
      check(n_wh, (w && ctl[7]) ? e_cmd : 0);
    end
    check(bus_type, ctl[7:6]);
    if (ctl[14] && !w || ctl[15] && w)
      check(n_cs, e_cmd);
  endtask
  task automatic t_bus;
    bus(16'h040F, 1'h0, 1, 1, 4);
    bus(16'h463D, 1'h0, 2, 3, 5);
    bus(16'h84B0, 1'h1, 1, 16, 17);
    bus(16'h000F, 1'h0, 0, 0, 0);
    bus(16'h143F, 1'h0, 1, -1, 0);
    bus(16'h343F, 1'h1, 1, -1, 0);
  endtask
  task automatic results;
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, acc_req, acc_write, long_reset, pol} = '0;
    {reg_addr, reg_wdata, data_port_in} = '0;
    acc_hit = 5'h00;
    ext_access_n = 1'h1;
    nrst = 1'h0;
    lag = 4;
    n_fail = 0;
    tests_run = 0;
    t_straps;
    t_regs;
    t_bus;
    results;
  end
  // About 400 cycles are expected; allow well over that
  initial begin
    #200000;
    n_fail++;
    results;
  end
endmodule // ebc_top_tb
bind ebc_top ebc_monitor i_mon (.clk(clk), .nrst(nrst), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .acc_req(acc_req),
  .acc_ready(acc_ready), .acc_hit(acc_hit), .latch_strobe(latch_strobe),
  .rd_n(rd_n), .wr_n(wr_n), .wr_low_n(wr_low_n), .cs_enable(cs_enable),
  .seg_enable(seg_enable), .bus_type(bus_type), .bus_wide(bus_wide),
  .bus_muxed(bus_muxed));
